// File: hdl/smr_ctrl.sv
// smr_ctrl.sv: status register, write latch and power state on the
// system clock.
// assumes: evt_in words are stable whenever their toggle has changed.

`timescale 1ns/1ns
`default_nettype none

module smr_ctrl #(
  parameter logic [11:0] ENTRY_CYC = smr_pkg::SLEEP_ENTRY_CYC,
  parameter logic [11:0] EXIT_CYC  = smr_pkg::SLEEP_EXIT_CYC
) (
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  input  wire logic                wp_n_in,
  input  wire logic [7:0]          nv_status_in,
  input  wire smr_pkg::smr_evt_s   evt_in,
  output var  smr_pkg::smr_guard_s guard_out,
  output var  logic                link_rst_out,
  output var  logic [7:0]          status_out,
  output var  logic                regs_on_out,
  output var  logic                low_power_out,
  output var  logic                ready_out
);
  import smr_pkg::*;

  smr_core_s c_reg;
  smr_core_s c_next;
  logic      evt_new;
  logic      status_ok;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    c_next          = c_reg;
    c_next.wp_meta  = wp_n_in;
    c_next.wp_sync  = c_reg.wp_meta;
    c_next.tgl_meta = evt_in.tgl;
    c_next.tgl_sync = c_reg.tgl_meta;
    c_next.tgl_seen = c_reg.tgl_sync;
    c_next.link_rst = 1'b0;
    evt_new         = c_reg.tgl_sync != c_reg.tgl_seen;
    status_ok       = c_reg.status[ST_LATCH] &&
                      !(c_reg.status[ST_LOCK] && !c_reg.wp_sync);
    if (c_reg.timer != 12'h000) begin
      c_next.timer = c_reg.timer - 12'h001;
    end
    unique case (c_reg.pwr)
      PWR_AWAKE: begin
        if (evt_new) begin
          case (evt_in.cmd)
            CMD_SET_LATCH:   c_next.status[ST_LATCH] = 1'b1;
            CMD_CLEAR_LATCH: c_next.status[ST_LATCH] = 1'b0;
            CMD_STATUS_WRITE: begin
              // refused writes leave every bit, latch included, alone
              if (status_ok) begin
                c_next.status = (evt_in.data & STATUS_WR_MASK) |
                                (c_reg.status & ~STATUS_WR_MASK);
              end
            end
            CMD_SLEEP: begin
              c_next.pwr     = PWR_ENTER;
              c_next.timer   = ENTRY_CYC - 12'h001;
              c_next.regs_on = 1'b0;
              c_next.asleep  = 1'b1;
              c_next.ready   = 1'b0;
            end
            default: ;
          endcase
        end
      end
      PWR_ENTER, PWR_ASLEEP: begin
        // only a wake is acted on here; others never reach this side
        if (evt_new && evt_in.cmd == CMD_WAKE) begin
          c_next.pwr     = PWR_EXIT;
          c_next.timer   = EXIT_CYC - 12'h001;
          c_next.regs_on = 1'b1;
          c_next.low_pwr = 1'b0;
        end else if (c_reg.pwr == PWR_ENTER && c_reg.timer == 12'h000) begin
          c_next.pwr     = PWR_ASLEEP;
          c_next.low_pwr = 1'b1;
        end
      end
      PWR_EXIT: begin
        // the host holds chip select high meanwhile, so no frame overlaps
        if (c_reg.timer == 12'h000) begin
          c_next.pwr    = PWR_AWAKE;
          c_next.asleep = 1'b0;
          c_next.ready  = 1'b1;
        end
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset stands for a power cycle: the stored image returns, the latch
  // and the power state do not
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      c_reg                  <= '0;
      c_reg.status           <= nv_status_in;
      c_reg.status[ST_LATCH] <= 1'b0;
      c_reg.pwr              <= PWR_AWAKE;
      c_reg.link_rst         <= 1'b1;
      c_reg.ready            <= 1'b1;
      c_reg.regs_on          <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  assign guard_out     = '{asleep: c_reg.asleep, status: c_reg.status};
  assign link_rst_out  = c_reg.link_rst;
  assign status_out    = c_reg.status;
  assign regs_on_out   = c_reg.regs_on;
  assign low_power_out = c_reg.low_pwr;
  assign ready_out     = c_reg.ready;

endmodule

`default_nettype wire

// File: hdl/smr_mram_top.sv
// smr_mram_top.sv: serial nonvolatile RAM command engine, link side and
// memory array; status and power state sit in smr_ctrl.
// assumes: sck_in, cs_n_in and si_in come straight from the pins, srst_in
// is synchronous to mclk_in and chip select stays high 4 mclk periods.
//
// How it works
// - write latch flag is 0 after power-up and after clear-latch command
// - status write needs latch set and protect pin plus lock bit allowing
// - status bits survive power cycles; only the write latch flag clears
// - read takes 24-bit address, uses bits 0-18, shifts out bytes on SO
// - read supplies bytes while SCK runs; chip select high ends it
// - address counter wraps to 0000H past the top of memory
// - write takes 24-bit address, decodes bits 0-18, stores bytes in turn
// - write data accepted at full clock rate until chip select rises
// - back-to-back writes to any address need no busy wait
// - sleep turns regulators off; low current after sleep entry delay
// - in sleep only wake is executed; other commands are ignored
// - power loss during sleep returns to normal standby
// - wake turns regulators on; standby after sleep exit delay
// - one command byte opens each frame; codes 01 02 03 05 B9 AB 06 04
// - memory writes need latch set and address outside guarded block

`timescale 1ns/1ns
`default_nettype none

module smr_mram_top #(
  parameter int ADDR_W = smr_pkg::MEM_AW
) (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  input  wire logic       wp_n_in,
  input  wire logic [7:0] nv_status_in,
  output var  logic       so_out,
  output var  logic       so_oe_out,
  output var  logic [7:0] status_out,
  output var  logic       regs_on_out,
  output var  logic       low_power_out,
  output var  logic       ready_out
);
  import smr_pkg::*;

  // ****************************************************************
  // link state
  // ****************************************************************
  typedef struct packed {
    smr_phase_e        phase;
    logic [2:0]        bitcnt;
    logic [6:0]        shift;
    logic [7:0]        cmd;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        abytes;
    logic [7:0]        rd_byte;
    smr_guard_s        meta;
    smr_guard_s        sync;
  } smr_link_s;

  smr_link_s         l_reg;
  smr_link_s         l_next;
  smr_evt_s          evt_reg;
  smr_guard_s        guard;
  logic              link_rst;
  logic [7:0]        rx_byte;
  logic [ADDR_W-1:0] addr_full;
  logic              evt_fire;
  logic [7:0]        evt_cmd_next;
  logic [7:0]        evt_data_next;
  logic              mem_we;

  // whole array is held here; nonvolatility is the storage cell's job
  logic [7:0] mem [0:(1 << ADDR_W) - 1];

  // ****************************************************************
  // block guard decode
  // ****************************************************************
  function automatic logic guarded(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        st);
    logic hit;
    hit = 1'b0;
    unique case ({st[ST_GUARD_HIGH], st[ST_GUARD_LOW]})
      2'h0: hit = 1'b0;
      2'h1: hit = a[ADDR_W-1] & a[ADDR_W-2];
      2'h2: hit = a[ADDR_W-1];
      2'h3: hit = 1'b1;
    endcase
    guarded = !st[ST_LATCH] || hit;
  endfunction

  // ****************************************************************
  // link next state: one step per rising SCK edge
  // ****************************************************************
  always_comb begin
    l_next        = l_reg;
    evt_fire      = 1'b0;
    evt_cmd_next  = l_reg.cmd;
    evt_data_next = 8'h00;
    mem_we        = 1'b0;
    rx_byte       = {l_reg.shift, si_in};
    addr_full     = {l_reg.addr[ADDR_W-9:0], rx_byte};
    l_next.meta   = guard;
    l_next.sync   = l_reg.meta;
    l_next.shift  = rx_byte[6:0];
    l_next.bitcnt = l_reg.bitcnt + 3'h1;
    // a byte completes every eighth edge of the frame
    if (l_reg.bitcnt == 3'h7) begin
      unique case (l_reg.phase)
        PH_CMD: begin
          l_next.cmd   = rx_byte;
          l_next.phase = PH_IDLE;
          if (!l_reg.sync.asleep || rx_byte == CMD_WAKE) begin
            case (rx_byte)
              CMD_READ, CMD_WRITE: begin
                l_next.phase  = PH_ADDR;
                l_next.abytes = 2'h0;
              end
              CMD_STATUS_WRITE: l_next.phase = PH_SDATA;
              CMD_STATUS_READ: begin
                l_next.phase   = PH_SOUT;
                l_next.rd_byte = l_reg.sync.status;
              end
              CMD_SET_LATCH, CMD_CLEAR_LATCH, CMD_SLEEP, CMD_WAKE: begin
                evt_fire     = 1'b1;
                evt_cmd_next = rx_byte;
              end
              default: ;
            endcase
          end
        end
        PH_ADDR: begin
          // upper address bits fall off the top of the shift
          l_next.addr   = addr_full;
          l_next.abytes = l_reg.abytes + 2'h1;
          if (l_reg.abytes == ADDR_LAST_BYTE) begin
            if (l_reg.cmd == CMD_READ) begin
              l_next.phase   = PH_RDATA;
              l_next.rd_byte = mem[addr_full];
              l_next.addr    = addr_full + ADDR_W'(1);
            end else begin
              l_next.phase = PH_WDATA;
            end
          end
        end
        PH_WDATA: begin
          // no busy time: each byte lands on its own edge
          mem_we      = !guarded(l_reg.addr, l_reg.sync.status);
          l_next.addr = l_reg.addr + ADDR_W'(1);
        end
        PH_RDATA: begin
          l_next.rd_byte = mem[l_reg.addr];
          l_next.addr    = l_reg.addr + ADDR_W'(1);
        end
        PH_SOUT: l_next.rd_byte = l_reg.sync.status;
        PH_SDATA: begin
          // only the first data byte counts; later ones are ignored
          evt_fire      = 1'b1;
          evt_cmd_next  = CMD_STATUS_WRITE;
          evt_data_next = rx_byte;
          l_next.phase  = PH_IDLE;
        end
        PH_IDLE: ;
      endcase
    end
  end

  // ****************************************************************
  // link registers: chip select high clears the frame state
  // ****************************************************************
  // the link clock stops between frames, so the frame's own select ends
  // everything that must not outlive it
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // completed commands cross by toggle; words stay put until the next one
  always_ff @(posedge sck_in or posedge link_rst) begin
    if (link_rst) begin
      evt_reg <= '0;
    end else if (evt_fire) begin
      evt_reg <= '{tgl: ~evt_reg.tgl, cmd: evt_cmd_next,
                   data: evt_data_next};
    end
  end

  always_ff @(posedge sck_in) begin
    if (mem_we) begin
      mem[l_reg.addr] <= rx_byte;
    end
  end

  // ****************************************************************
  // serial output on the falling edge
  // ****************************************************************
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= l_reg.phase == PH_RDATA ||
                   l_reg.phase == PH_SOUT;
      so_out    <= l_reg.rd_byte[~l_reg.bitcnt];
    end
  end

  // ****************************************************************
  // system clock side
  // ****************************************************************
  smr_ctrl u_ctrl (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .wp_n_in       (wp_n_in),
    .nv_status_in  (nv_status_in),
    .evt_in        (evt_reg),
    .guard_out     (guard),
    .link_rst_out  (link_rst),
    .status_out    (status_out),
    .regs_on_out   (regs_on_out),
    .low_power_out (low_power_out),
    .ready_out     (ready_out)
  );

endmodule

`default_nettype wire

// File: hdl/smr_pkg.sv
// smr_pkg.sv: shared constants, enumerations and carriers of the serial
// nonvolatile RAM command engine.
// assumes: the system clock runs at 10 MHz.

package smr_pkg;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_WRITE        = 8'h02;
  localparam logic [7:0] CMD_READ         = 8'h03;
  localparam logic [7:0] CMD_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
  localparam logic [7:0] CMD_SET_LATCH    = 8'h06;
  localparam logic [7:0] CMD_SLEEP        = 8'hB9;
  localparam logic [7:0] CMD_WAKE         = 8'hAB;

  // ****************************************************************
  // array and status layout
  // ****************************************************************
  localparam int         MEM_AW          = 19;
  localparam logic [1:0] ADDR_LAST_BYTE  = 2'h2;
  localparam int         ST_LOCK         = 7;
  localparam int         ST_GUARD_HIGH   = 3;
  localparam int         ST_GUARD_LOW    = 2;
  localparam int         ST_LATCH        = 1;
  // every bit but the write latch flag is taken from the data byte
  localparam logic [7:0] STATUS_WR_MASK  = 8'hFD;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          MCLK_PERIOD_NS  = 100;
  localparam int          SLEEP_ENTRY_NS  = 3000;
  localparam int          SLEEP_EXIT_NS   = 400000;
  localparam int          TIMER_W         = 12;
  localparam logic [11:0] SLEEP_ENTRY_CYC =
    12'((SLEEP_ENTRY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [11:0] SLEEP_EXIT_CYC  =
    12'((SLEEP_EXIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_AWAKE  = 2'h0,
    PWR_ENTER  = 2'h1,
    PWR_ASLEEP = 2'h3,
    PWR_EXIT   = 2'h2
  } smr_pwr_e;

  typedef enum logic [2:0] {
    PH_CMD   = 3'h0,
    PH_ADDR  = 3'h1,
    PH_WDATA = 3'h3,
    PH_RDATA = 3'h2,
    PH_SDATA = 3'h6,
    PH_SOUT  = 3'h7,
    PH_IDLE  = 3'h5
  } smr_phase_e;

  // levels handed from the system clock side to the link side
  typedef struct packed {
    logic       asleep;
    logic [7:0] status;
  } smr_guard_s;

  // completed command handed from the link side, marked by a toggle
  typedef struct packed {
    logic       tgl;
    logic [7:0] cmd;
    logic [7:0] data;
  } smr_evt_s;

  typedef struct packed {
    logic [7:0]   status;
    smr_pwr_e     pwr;
    logic [11:0]  timer;
    logic         wp_meta;
    logic         wp_sync;
    logic         tgl_meta;
    logic         tgl_sync;
    logic         tgl_seen;
    logic         link_rst;
    logic         asleep;
    logic         ready;
    logic         regs_on;
    logic         low_pwr;
  } smr_core_s;

endpackage

// File: test/smr_mram_bench.sv
// smr_mram_bench.sv: self-checking bench for smr_mram_top.
// assumes: smr_spi_host plays the bus host; mclk runs at 10 MHz.
`timescale 1ns/1ns
`default_nettype none
module smr_mram_bench;
  import smr_pkg::*;
  logic       mclk;
  logic       srst = 1'b1;
  logic       wp_n = 1'b1;
  logic [7:0] nv = 8'h73;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       so;
  logic       so_oe;
  logic [7:0] st;
  logic       regs_on;
  logic       low_pwr;
  logic       ready;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         n;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  smr_mram_top u_dut (
    .mclk_in(mclk), .srst_in(srst), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .wp_n_in(wp_n), .nv_status_in(nv), .so_out(so),
    .so_oe_out(so_oe), .status_out(st), .regs_on_out(regs_on),
    .low_power_out(low_pwr), .ready_out(ready));
  smr_spi_host u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .so_in(so), .so_oe_in(so_oe));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic power_up(input logic [7:0] v);
    nv = v;
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    tick(3);
  endtask
  task automatic send(input logic [7:0] tx[$], input int nr);
    u_host.frame(tx, nr);
    tick(1);
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d[$]);
    logic [7:0] tx[$];
    tx = {CMD_WRITE, a[23:16], a[15:8], a[7:0], d};
    send(tx, 0);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e[$]);
    send('{CMD_READ, a[23:16], a[15:8], a[7:0]}, e.size());
    check(u_host.oe_seen, 1'b1);
    foreach (e[i]) check(u_host.rx_q[i], e[i]);
  endtask
  // a hang ends the run through the same report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    power_up(8'h73);
    check(st, 8'h71);
    $display("test power-up done");
    send('{CMD_SET_LATCH}, 0);
    check(st[1], 1'b1);
    wr(24'hF7FFFE, '{8'hA1, 8'hA2, 8'hA3});
    wr(24'h000001, '{8'hB4});
    rd(24'h07FFFE, '{8'hA1, 8'hA2, 8'hA3, 8'hB4});
    send('{CMD_CLEAR_LATCH}, 0);
    check(st, 8'h71);
    wr(24'h000000, '{8'h5A});
    rd(24'h000000, '{8'hA3});
    $display("test array done");
    send('{CMD_STATUS_WRITE, 8'h8C}, 0);
    check(st, 8'h71);
    send('{CMD_SET_LATCH}, 0);
    send('{CMD_STATUS_WRITE, 8'h8C}, 0);
    check(st, 8'h8E);
    send('{CMD_STATUS_READ}, 1);
    check(u_host.rx_q[0], 8'h8E);
    wp_n = 1'b0;
    send('{CMD_STATUS_WRITE, 8'h00}, 0);
    check(st, 8'h8E);
    wr(24'h000000, '{8'h77});
    rd(24'h000000, '{8'hA3});
    wp_n = 1'b1;
    send('{CMD_STATUS_WRITE, 8'h04}, 0);
    check(st, 8'h06);
    wr(24'h07FFFF, '{8'hC5, 8'hD6});
    rd(24'h07FFFF, '{8'hA2, 8'hD6});
    $display("test protection done");
    send('{CMD_SLEEP}, 0);
    check({regs_on, ready, low_pwr}, 3'b000);
    tick(40);
    check(low_pwr, 1'b1);
    send('{CMD_CLEAR_LATCH}, 0);
    send('{CMD_READ, 8'h00, 8'h00, 8'h00}, 1);
    check({st[1], u_host.oe_seen}, 2'b10);
    send('{CMD_WAKE}, 0);
    check({regs_on, low_pwr, ready}, 3'b100);
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    check(n > 3900 && n < 4010, 1'b1);
    rd(24'h000000, '{8'hD6});
    $display("test sleep done");
    send('{CMD_SLEEP}, 0);
    tick(40);
    power_up(8'h06);
    check({st, regs_on, low_pwr, ready}, {8'h04, 3'b101});
    rd(24'h07FFFF, '{8'hA2});
    $display("test power loss done");
    final_report();
  end
endmodule
`default_nettype wire

// File: test/smr_mram_chk.sv
// smr_mram_chk.sv: port assertions for smr_mram_top, bound below.
// assumes: nv_status_in holds steady while reset is released.
`timescale 1ns/1ns
`default_nettype none
module smr_mram_chk #(
  parameter int ADDR_W = 19
) (
  input wire logic       mclk_in,
  input wire logic       srst_in,
  input wire logic       sck_in,
  input wire logic       cs_n_in,
  input wire logic       si_in,
  input wire logic       wp_n_in,
  input wire logic [7:0] nv_status_in,
  input wire logic       so_out,
  input wire logic       so_oe_out,
  input wire logic [7:0] status_out,
  input wire logic       regs_on_out,
  input wire logic       low_power_out,
  input wire logic       ready_out
);
  import smr_pkg::*;
  // ****************
  // helpers
  // ****************
  logic [5:0]  n_edge;
  logic [7:0]  op;
  logic [12:0] up_cnt;
  logic [5:0]  dn_cnt;
  // frame state clears with chip select, as the link logic does
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      n_edge <= 6'h00;
      op     <= 8'h00;
    end else begin
      if (n_edge != 6'h3F) n_edge <= n_edge + 6'h01;
      if (n_edge < 6'h08) op <= {op[6:0], si_in};
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in || !regs_on_out) up_cnt <= 13'h0000;
    else if (up_cnt != 13'h1FFF) up_cnt <= up_cnt + 13'h0001;
  end
  // cycles since the regulators went off, saturating
  always_ff @(posedge mclk_in) begin
    if (srst_in || regs_on_out) dn_cnt <= 6'h00;
    else if (dn_cnt != 6'h3F) dn_cnt <= dn_cnt + 6'h01;
  end
  sequence s_enter;
    !low_power_out [*8] ##[12:32] (low_power_out || regs_on_out);
  endsequence
  // ****************
  // assertions
  // ****************
  AST_RESET_LOAD: assert property (
    @(posedge mclk_in) disable iff (srst_in) $fell(srst_in) |->
    status_out == (nv_status_in & STATUS_WR_MASK) && ready_out &&
    regs_on_out && !low_power_out) else $error("bad state after reset");
  AST_SLEEP_ENTRY: assert property (
    @(posedge mclk_in) disable iff (srst_in) $fell(regs_on_out) |-> s_enter)
    else $error("sleep current not reached in time");
  AST_ENTRY_MIN: assert property (
    @(posedge mclk_in) disable iff (srst_in) $rose(low_power_out) |->
    dn_cnt >= 6'(SLEEP_ENTRY_CYC)) else $error("sleep current too early");
  AST_EXIT_TIME: assert property (
    @(posedge mclk_in) disable iff (srst_in) $rose(ready_out) |->
    up_cnt >= 13'h0F96 && up_cnt <= 13'h0FAA) else $error("exit delay off");
  AST_EXIT_BOUND: assert property (
    @(posedge mclk_in) disable iff (srst_in) regs_on_out && !ready_out
    |-> up_cnt < 13'h0FAA) else $error("standby not reached after wake");
  AST_SLEEP_READY: assert property (
    @(posedge mclk_in) disable iff (srst_in) !regs_on_out |-> !ready_out)
    else $error("ready while regulators off");
  AST_LOW_REGS: assert property (
    @(posedge mclk_in) disable iff (srst_in) low_power_out |-> !regs_on_out)
    else $error("low power with regulators on");
  AST_OE_IDLE: assert property (
    @(posedge mclk_in) disable iff (srst_in) cs_n_in |-> !so_oe_out)
    else $error("output driven while deselected");
  AST_ASLEEP_MUTE: assert property (
    @(posedge mclk_in) disable iff (srst_in) !ready_out |-> !so_oe_out)
    else $error("output driven while asleep");
  AST_STATUS_HOLD: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    !ready_out && !$past(ready_out) |-> $stable(status_out))
    else $error("status changed while asleep");
  AST_OE_CMD: assert property (
    @(posedge sck_in) disable iff (cs_n_in) n_edge < 6'h08 |-> !so_oe_out)
    else $error("output driven during command byte");
  AST_READ_OE: assert property (
    @(posedge sck_in) disable iff (cs_n_in)
    n_edge == 6'h20 && op == CMD_READ && ready_out |-> so_oe_out)
    else $error("read data not driven after address");
  AST_WRITE_QUIET: assert property (
    @(posedge sck_in) disable iff (cs_n_in)
    n_edge >= 6'h08 && op == CMD_WRITE |-> !so_oe_out)
    else $error("output driven during write");
endmodule
bind smr_mram_top smr_mram_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_in(mclk_in), .srst_in(srst_in), .sck_in(sck_in),
  .cs_n_in(cs_n_in), .si_in(si_in), .wp_n_in(wp_n_in),
  .nv_status_in(nv_status_in), .so_out(so_out), .so_oe_out(so_oe_out),
  .status_out(status_out), .regs_on_out(regs_on_out),
  .low_power_out(low_power_out), .ready_out(ready_out)
);
`default_nettype wire

// File: test/smr_spi_host.sv
// smr_spi_host.sv: bus host model that frames commands for the block.
// assumes: the bench calls frame() and waits out the wake delay itself.
`timescale 1ns/1ns
`default_nettype none
module smr_spi_host (
  output var  logic sck_out,
  output var  logic cs_n_out,
  output var  logic si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  // ****************
  // frame engine
  // ****************
  logic [7:0] rx_q[$];
  logic       oe_seen;
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
    oe_seen  = 1'b0;
  end
  // mode 0, 32 ns link clock that stands low between frames
  task automatic frame(input logic [7:0] tx[$], input int n_rd);
    logic [7:0] b;
    rx_q = {};
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    #16;
    for (int i = 0; i < tx.size() + n_rd; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        si_out = b[k];
        #16;
        sck_out = 1'b1;
        // a released line reads inverted so a stale level never passes
        b[k] = so_oe_in ? so_in : ~so_in;
        oe_seen = oe_seen | so_oe_in;
        #16;
        sck_out = 1'b0;
      end
      if (i >= tx.size()) begin
        rx_q.push_back(b);
      end
    end
    #16;
    cs_n_out = 1'b1;
    // flip the idle SI line so a stale level never reads as data
    si_out = ~si_out;
    #600;
  endtask
endmodule
`default_nettype wire
